// File: diag_bank.sv
// diagnostic status bank: read-only registers selected by subaddress.
// assumes fault inputs come from other clock domains and are resynchronised.
// Contract
// - four ignition codes, stage4 in 7:6 down to stage1 in 1:0
// - relay overcurrent bit 6 shows driver held off after overcurrent
// - tracker codes 2-bit; overload beats overvoltage/overtemp
// - bit 7 of reset-cause set when tracker logic caused reset
// - group one fault in bit 6
// - group two fault in bit 4
// - logic supply overvoltage in bit 3
// - low rail undervoltage in bit 2
// - output-disable bit 1 keeps outputs off except relay and supplies
// - while latch set, stage data ignored; start command clears latch
// - reads keep latch; set by power-on, soft reset, reset pin
// - battery overvoltage shutoff in bit 0
// - four overtemp flags in bits 7 to 4
// - bus error bit when any transceiver error present
// - latched watchdog fault in bit 1 of register eleven
// - injector switch-off event in bit 5
// - outputs 13/14 switch-off event in bit 4
// - live watchdog flag bit 3; latched bit 6 cleared by other read
// - response time 1+101*setting reference periods; resets to 0x3f
// - each setting write increments error counter by one, holding at 7
// - lock does not protect the setting
// - reading register ten, eleven or twelve clears its sticky bits, except the latch and bit 6 of twelve
// - register fourteen: limit flag, counter, question
module diag_bank import diag_bank_pkg::*; (
  input  wire logic          i_core_clk,
  input  wire logic          i_rst,
  input  wire logic          i_rd_stb,
  input  wire logic [7:0]    i_rd_sub,
  output logic      [7:0]    o_rd_data,
  output logic               o_rd_valid,
  input  wire logic          i_wr_interval,
  input  wire logic [5:0]    i_wr_interval_data,
  input  wire logic          i_lock_cmd,
  input  wire logic          i_start_cmd,
  input  wire logic          i_soft_reset_cmd,
  input  wire logic          i_reset_pin_n,
  input  wire logic          i_stage_wr,
  input  wire logic [7:0]    i_stage_data,
  output logic      [7:0]    o_stage_cmd,
  output logic               o_outputs_enabled,
  input  wire logic [7:0]    i_ign_codes,
  input  wire logic          i_relay_ovc,
  input  wire logic [1:0]    i_trk1_overload,
  input  wire logic [1:0]    i_trk1_ovot_pair,
  input  wire logic          i_key_level,
  input  wire logic          i_key_filtered,
  input  wire logic          i_speed_diag_on,
  input  wire logic          i_speed_fault,
  input  wire logic          i_wd_live,
  input  wire logic [3:0]    i_question,
  input  wire fault_events_s i_events,
  output logic      [12:0]   o_resp_ticks,
  output logic      [2:0]    o_err_count
);

  // two-flop synchronisers for all asynchronous inputs; stage 1 read only by stage 2
  localparam int unsigned SW = 8 + 1 + 2 + 2 + 1 + 1 + 1 + 1 + 1 + 1 + 4 + $bits(fault_events_s);
  logic [SW-1:0] sync1_r, sync2_r, raw;
  assign raw = {i_ign_codes, i_relay_ovc, i_trk1_overload, i_trk1_ovot_pair, i_key_level,
                i_key_filtered, i_speed_diag_on, i_speed_fault, i_reset_pin_n, i_wd_live,
                i_question, i_events};
  always_ff @(posedge i_core_clk) begin
    sync1_r <= i_rst ? '0 : raw;
    sync2_r <= i_rst ? '0 : sync1_r;
  end

  logic [7:0]    ign_s;
  logic          ovc_s, key_s, keyf_s, vrs_on_s, vrs_f_s, rstpin_n_s, wd_live_s;
  logic [1:0]    overload_s, ovot_s;
  logic [3:0]    quest_s;
  fault_events_s ev;
  assign {ign_s, ovc_s, overload_s, ovot_s, key_s, keyf_s, vrs_on_s, vrs_f_s, rstpin_n_s,
          wd_live_s, quest_s, ev} = sync2_r;

  // tracker codes: overload 01 wins over overvoltage/overtemp 10
  logic [1:0] trk_code [2];
  for (genvar t = 0; t < 2; t++) begin : g_trk
    always_comb begin
      if (overload_s[t])
        trk_code[t] = 2'h1;
      else if (ovot_s[t])
        trk_code[t] = 2'h2;
      else
        trk_code[t] = 2'h3;
    end
  end

  // state group: sticky flags, latch, setting, error counter
  logic [7:0] reset_flags_r, reset_flags_nxt;        // reg 10 sticky, bit1 unused
  logic [7:0] ot_flags_r,    ot_flags_nxt;           // reg 11 sticky
  logic [1:0] seo_r,         seo_nxt;                // reg 12 bits 5,4
  logic       wd_held_r,     wd_held_nxt;            // latched watchdog fault
  logic       output_disable_latch_r,     output_disable_latch_nxt;
  logic [5:0] interval_r,    interval_nxt;
  logic [2:0] watchdog_error_count_r,     watchdog_error_count_nxt;
  logic [7:0] stage_r,       stage_nxt;
  logic [7:0] rd_data_r,     rd_data_nxt;
  logic       rd_valid_r,    rd_valid_nxt;
  logic       rd10, rd11, rd12;

  assign rd10 = i_rd_stb && (i_rd_sub == SUB_RESET);
  assign rd11 = i_rd_stb && (i_rd_sub == SUB_OVERTEMP);
  assign rd12 = i_rd_stb && (i_rd_sub == SUB_SWOFF);

  // events set their flags; a read clears, but an event in the same cycle wins
  always_comb begin
    logic [7:0] set10, set11;
    set10 = {ev.tracker_reset, ev.group_one, ev.short_uv_reset, ev.group_two,
             ev.logic_ov, ev.low_rail_uv, 1'b0, ev.battery_ov};
    set11 = {ev.overtemp, ev.long_uv_reset, ev.bus_error, 1'b0, 1'b0};
    reset_flags_nxt = (rd10 ? 8'h00 : reset_flags_r) | set10;
    ot_flags_nxt    = (rd11 ? 8'h00 : ot_flags_r) | set11;
    seo_nxt         = (rd12 ? 2'h0 : seo_r) | {ev.seo_inject, ev.seo_out1314};
    // the held copy clears only on the register eleven read, not twelve
    wd_held_nxt     = (rd11 ? 1'b0 : wd_held_r) | ev.watchdog_reset;
    // latch: set by soft reset or reset pin, cleared only by start; reads ignored
    output_disable_latch_nxt = output_disable_latch_r;
    if (i_start_cmd)
      output_disable_latch_nxt = 1'b0;
    if (i_soft_reset_cmd || !rstpin_n_s)
      output_disable_latch_nxt = 1'b1;
    // lock has no effect on the interval setting
    interval_nxt = i_wr_interval ? i_wr_interval_data : interval_r;
    watchdog_error_count_nxt  = watchdog_error_count_r;
    if (i_wr_interval && watchdog_error_count_r != 3'h7)
      watchdog_error_count_nxt = watchdog_error_count_r + 3'h1;
    // stage data is dropped while outputs are disabled
    stage_nxt = stage_r;
    if (output_disable_latch_r)
      stage_nxt = 8'h00;
    else if (i_stage_wr)
      stage_nxt = i_stage_data;
    rd_valid_nxt = i_rd_stb;
    rd_data_nxt  = rd_data_r;
    if (i_rd_stb) begin
      case (i_rd_sub)
        SUB_IGN:      rd_data_nxt = ign_s;
        SUB_SUPPLY:   rd_data_nxt = {key_s, ovc_s, vrs_on_s, vrs_f_s,
                                     trk_code[1], trk_code[0]};
        SUB_RESET:    rd_data_nxt = {reset_flags_r[7:2], output_disable_latch_r, reset_flags_r[0]};
        SUB_OVERTEMP: rd_data_nxt = {ot_flags_r[7:2], wd_held_r, 1'b0};
        SUB_SWOFF:    rd_data_nxt = {1'b0, wd_held_r, seo_r, wd_live_s, 2'h0, keyf_s};
        SUB_RESP:     rd_data_nxt = {2'h0, interval_r};
        SUB_QUEST:    rd_data_nxt = {watchdog_error_count_r > ERR_LIMIT, watchdog_error_count_r, quest_s};
        default:      rd_data_nxt = 8'h00;
      endcase
    end
  end

  // power-on reset sets the latch and the interval default
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      reset_flags_r <= RST_DIAG;
      ot_flags_r    <= RST_DIAG;
      seo_r         <= 2'h0;
      wd_held_r     <= 1'b0;
      output_disable_latch_r     <= 1'b1;
      interval_r    <= RST_RESPONSE_INTERVAL_SETTING;
      watchdog_error_count_r     <= RST_QUEST[6:4];
      stage_r       <= 8'h00;
      rd_data_r     <= 8'h00;
      rd_valid_r    <= 1'b0;
    end else begin
      reset_flags_r <= reset_flags_nxt;
      ot_flags_r    <= ot_flags_nxt;
      seo_r         <= seo_nxt;
      wd_held_r     <= wd_held_nxt;
      output_disable_latch_r     <= output_disable_latch_nxt;
      interval_r    <= interval_nxt;
      watchdog_error_count_r     <= watchdog_error_count_nxt;
      stage_r       <= stage_nxt;
      rd_data_r     <= rd_data_nxt;
      rd_valid_r    <= rd_valid_nxt;
    end
  end

  assign o_rd_data         = rd_data_r;
  assign o_rd_valid        = rd_valid_r;
  assign o_stage_cmd       = stage_r;
  assign o_outputs_enabled = !output_disable_latch_r;
  assign o_err_count       = watchdog_error_count_r;
  // response interval in reference periods; the largest, 1+101*63, needs 13 bits
  logic [12:0] ticks_full;
  assign ticks_full   = 13'(1 + RESP_MULT * interval_r);
  assign o_resp_ticks = ticks_full;

  // checks
  a_interval_count: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_wr_interval && watchdog_error_count_r != 3'h7 |=> watchdog_error_count_r == $past(watchdog_error_count_r) + 3'h1)
    else $error("interval write did not bump error count");
  a_interval_value: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_wr_interval |=> interval_r == $past(i_wr_interval_data))
    else $error("interval write lost");
  a_latch_blocks: assert property (@(posedge i_core_clk) disable iff (i_rst)
    output_disable_latch_r |=> stage_r == 8'h00)
    else $error("stage data passed while disabled");
  a_latch_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
    output_disable_latch_r && !i_start_cmd |=> output_disable_latch_r)
    else $error("latch cleared without start");
  a_softrst_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_soft_reset_cmd |=> output_disable_latch_r && !o_outputs_enabled)
    else $error("soft reset did not set latch");
  a_event_wins: assert property (@(posedge i_core_clk) disable iff (i_rst)
    rd10 && ev.group_one |=> reset_flags_r[6])
    else $error("event lost against read clear");
  a_read_clears: assert property (@(posedge i_core_clk) disable iff (i_rst)
    rd11 && !ev.overtemp[3] |=> !ot_flags_r[7])
    else $error("overtemp flag not cleared by read");
  // the counter may move in the read cycle, so compare against its value then
  a_quest_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_rd_stb && i_rd_sub == SUB_QUEST |=> o_rd_valid
      && o_rd_data[7] == ($past(watchdog_error_count_r) > ERR_LIMIT)
      && o_rd_data[6:4] == $past(watchdog_error_count_r))
    else $error("register fourteen content wrong");
  a_tracker_prio: assert property (@(posedge i_core_clk) disable iff (i_rst)
    overload_s[0] |-> trk_code[0] == 2'h1)
    else $error("tracker priority wrong");
  c_read_quest:  cover property (@(posedge i_core_clk) i_rd_stb && i_rd_sub == SUB_QUEST);
  c_start:       cover property (@(posedge i_core_clk) output_disable_latch_r ##1 !output_disable_latch_r);
  c_stage_write: cover property (@(posedge i_core_clk) !output_disable_latch_r && i_stage_wr);

endmodule

// File: diag_bank_pkg.sv
// package for the diagnostic status bank: subaddresses, field positions,
// reset values and timing constants. assumes a 125 MHz core clock.
package diag_bank_pkg;

  localparam logic [7:0] SUB_IGN      = 8'h08;
  localparam logic [7:0] SUB_SUPPLY   = 8'h09;
  localparam logic [7:0] SUB_RESET    = 8'h0a;
  localparam logic [7:0] SUB_OVERTEMP = 8'h0b;
  localparam logic [7:0] SUB_SWOFF    = 8'h0c;
  localparam logic [7:0] SUB_RESP     = 8'h0d;
  localparam logic [7:0] SUB_QUEST    = 8'h0e;

  localparam logic [7:0] RST_DIAG     = 8'h00;
  localparam logic [5:0] RST_RESPONSE_INTERVAL_SETTING = 6'h3f;
  localparam logic [7:0] RST_QUEST    = 8'he0;

  // response time = (1 + 101*setting) periods of the 64 kHz reference
  localparam int unsigned RESP_MULT   = 101;
  localparam int unsigned REF_HZ      = 64000;
  localparam int unsigned CORE_HZ     = 125000000;
  localparam int unsigned REF_DIV     = CORE_HZ / REF_HZ;
  localparam logic [2:0]  ERR_LIMIT   = 3'h4;

  // sticky fault inputs sampled from the analog/fault side
  typedef struct packed {
    logic       tracker_reset;
    logic       group_one;
    logic       short_uv_reset;
    logic       group_two;
    logic       logic_ov;
    logic       low_rail_uv;
    logic       battery_ov;
    logic [3:0] overtemp;      // tracker, stage, relay, low rail
    logic       long_uv_reset;
    logic       bus_error;     // any of four transceiver errors
    logic       watchdog_reset;
    logic       seo_inject;
    logic       seo_out1314;
  } fault_events_s;

endpackage

// File: host_model.sv
// host model: issues single-byte reads and takes the answer byte.
// assumes the bank answers with a one-cycle valid after each strobe.
module host_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_sub,
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_valid,
  output logic            o_rd_stb,
  output logic      [7:0] o_rd_sub,
  output logic      [7:0] o_data,
  output logic            o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_rd_stb = 1'b0;
    o_rd_sub = 8'h00;
  end
  // sub scrambled between reads so no stale address is relied on
  always @(posedge i_core_clk) begin
    o_rd_stb <= i_go;
    o_rd_sub <= i_go ? i_sub : ~o_rd_sub;
    o_done   <= i_rd_valid;
    if (i_rd_valid) begin
      o_data <= i_rd_data; // byte taken at the valid edge
    end
  end
endmodule

// File: test_engine_ctrl_diag_status_bank.sv
// self-checking bench for the diagnostic status bank.
// assumes a 125 MHz clock and reads made through the host model.
module test_engine_ctrl_diag_status_bank import diag_bank_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, go, stb, valid, done, wr_int, lock, start, sres, pin_n, st_wr;
  logic key_lv, key_f, relay, sp_on, sp_f, wd_live, en;
  logic [7:0] sub, rsub, rdata, hdata, st_data, st_cmd, ign;
  logic [5:0] wr_val;
  logic [1:0] t_ovl, t_ovot;
  logic [3:0] quest;
  logic [12:0] ticks;
  logic [2:0] errc;
  fault_events_s ev;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  diag_bank uut (.i_core_clk(clk), .i_rst(rst), .i_rd_stb(stb), .i_rd_sub(rsub),
    .o_rd_data(rdata), .o_rd_valid(valid), .i_wr_interval(wr_int),
    .i_wr_interval_data(wr_val), .i_lock_cmd(lock), .i_start_cmd(start),
    .i_soft_reset_cmd(sres), .i_reset_pin_n(pin_n), .i_stage_wr(st_wr),
    .i_stage_data(st_data), .o_stage_cmd(st_cmd), .o_outputs_enabled(en),
    .i_ign_codes(ign), .i_relay_ovc(relay), .i_trk1_overload(t_ovl),
    .i_trk1_ovot_pair(t_ovot), .i_key_level(key_lv), .i_key_filtered(key_f),
    .i_speed_diag_on(sp_on), .i_speed_fault(sp_f), .i_wd_live(wd_live),
    .i_question(quest), .i_events(ev), .o_resp_ticks(ticks), .o_err_count(errc));
  host_model host (.i_core_clk(clk), .i_go(go), .i_sub(sub), .i_rd_data(rdata),
    .i_rd_valid(valid), .o_rd_stb(stb), .o_rd_sub(rsub), .o_data(hdata), .o_done(done));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      test_done();
    end
  end
  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [12:0] exp, logic [12:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // inputs move 1 ns after the edge, clear of sampling
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(logic [7:0] s, logic [7:0] exp, string nm);
    int k = 0;
    go = 1'b1;
    sub = s;
    tick(1);
    go = 1'b0;
    while (done !== 1'b1 && k < 10) begin
      tick(1);
      k++;
    end
    chk("rd_answered", 13'h0001, {12'h000, done});
    chk(nm, {5'h00, exp}, {5'h00, hdata});
  endtask
  task automatic stw(logic [7:0] d);
    st_wr = 1'b1;
    st_data = d;
    tick(1);
    st_wr = 1'b0;
    tick(3);
  endtask
  task automatic t_reset();
    rd(8'h0a, 8'h02, "reset_cause");
    rd(8'h0d, 8'h3f, "resp_time");
    rd(8'h0e, 8'he5, "quest_errs");
    rd(8'h20, 8'h00, "unmapped");
    chk("ticks", 13'h18dc, ticks);
    rd(8'h08, 8'h1b, "ign_codes");
    rd(8'h09, 8'he9, "supply_key");
    $display("test reset and status done");
  endtask
  // every event at once, then reads in an order that shows the clears
  task automatic t_events();
    ev = '1;
    tick(1);
    ev = '0;
    tick(4);
    rd(8'h0c, 8'h79, "swoff_wd");
    rd(8'h0a, 8'hff, "reset_groups");
    rd(8'h0b, 8'hfe, "overtemp");
    rd(8'h0a, 8'h02, "reset_groups2");
    rd(8'h0b, 8'h00, "overtemp2");
    rd(8'h0c, 8'h09, "swoff_wd2");
    $display("test events done");
  endtask
  task automatic t_latch();
    stw(8'h5a);
    chk("stage_locked", 13'h0000, {5'h00, st_cmd});
    chk("out_en", 13'h0000, {12'h000, en});
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(3);
    rd(8'h0a, 8'h00, "latch_clr");
    stw(8'h5a);
    chk("stage_cmd", 13'h005a, {5'h00, st_cmd});
    chk("out_en1", 13'h0001, {12'h000, en});
    sres = 1'b1;
    tick(1);
    sres = 1'b0;
    tick(3);
    chk("stage_off", 13'h0000, {5'h00, st_cmd});
    rd(8'h0a, 8'h02, "latch_soft");
    start = 1'b1;
    tick(1);
    start = 1'b0;
    pin_n = 1'b0;
    tick(5);
    chk("out_en_pin", 13'h0000, {12'h000, en});
    pin_n = 1'b1;
    $display("test latch done");
  endtask
  task automatic t_interval();
    lock = 1'b1;
    wr_int = 1'b1;
    wr_val = 6'h02;
    tick(1);
    wr_int = 1'b0;
    tick(2);
    rd(8'h0d, 8'h02, "interval");
    chk("ticks2", 13'h00cb, ticks);
    chk("errs", 13'h0007, {10'h000, errc});
    rd(8'h0e, 8'hf5, "quest_errs2");
    wr_int = 1'b1;
    wr_val = 6'h00;
    tick(1);
    wr_int = 1'b0;
    tick(2);
    chk("ticks0", 13'h0001, ticks);
    $display("test interval done");
  endtask
  initial begin
    {rst, go, wr_int, lock, start, sres, st_wr, sp_f} = 8'hff;
    {go, wr_int, lock, start, sres, st_wr, sp_f} = 7'h00;
    {pin_n, key_lv, key_f, relay, sp_on, wd_live} = 6'h3f;
    sub = 8'h00;
    st_data = 8'h00;
    ign = 8'h1b;
    wr_val = 6'h00;
    t_ovl = 2'b01;
    t_ovot = 2'b11;
    quest = 4'h5;
    ev = '0;
    tick(8);
    rst = 1'b0;
    tick(3);
    t_reset();
    t_events();
    t_latch();
    t_interval();
    test_done();
  end
endmodule
